/* File: tms_pkg.sv */
package tms_pkg;
  // clock and long delays
  localparam longint unsigned CLK_HZ = 64'd20_000_000;
  localparam longint unsigned STEP_DLY_S = 64'd10;
  localparam longint unsigned WARM_DLY_MIN = 64'd10;
  localparam longint unsigned SEC_PER_MIN = 64'd60;
  localparam longint unsigned STEP_DLY_CYC = CLK_HZ * STEP_DLY_S;
  localparam longint unsigned WARM_DLY_CYC = CLK_HZ * WARM_DLY_MIN * SEC_PER_MIN;
  localparam int TMR_W = 34;
  // converter sync rate and monitor sampling
  localparam longint unsigned CONV_SYNC_HZ = 64'd5000;
  localparam logic [15:0] CONV_PERIOD_CYC = 16'(CLK_HZ / CONV_SYNC_HZ);
  localparam logic [15:0] MON_PERIOD_CYC = 16'h07d0;
  // blanking margins around the gate, in cycles
  localparam logic [15:0] BLANK_LEAD_CYC = 16'h0004;
  localparam logic [15:0] BLANK_LAG_CYC = 16'h0004;
  // duty limit as a ratio, and the longest burst in cycles
  localparam int unsigned DUTY_NUM = 29;
  localparam int unsigned DUTY_DEN = 1000;
  localparam int unsigned DUTY_BURST_CYC = 500;
  // register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STAT = 8'h04;
  localparam logic [7:0] REG_PW = 8'h08;
  localparam logic [7:0] REG_IST = 8'h0c;
  localparam logic [7:0] REG_IMSK = 8'h10;
  localparam logic [7:0] REG_MON = 8'h14;
  // field positions and pulse-width reset value
  localparam int CTRL_CLR_BIT = 2;
  localparam int STAT_TGT_LSB = 2;
  localparam int STAT_LAT_LSB = 4;
  localparam int STAT_LIVE_LSB = 8;
  localparam logic [15:0] PW_RST = 16'h0190;
  // fault inputs
  localparam int F_BODY = 0;
  localparam int F_REFL = 1;
  localparam int F_CATH = 2;
  localparam int F_BUS = 3;
  // interrupt status bits: [3:0] faults, then mode change, then duty trip
  localparam int IRQ_MODE = 4;
  localparam int IRQ_DUTY = 5;
  localparam int IRQ_W = 6;
  typedef enum logic [3:0] {
    M_OFF = 4'b0001,
    M_IDLE = 4'b0010,
    M_ARM = 4'b0100,
    M_RAD = 4'b1000
  } tms_mode_t;
  typedef enum logic [3:0] {
    P_IDLE = 4'b0001,
    P_LEAD = 4'b0010,
    P_GATE = 4'b0100,
    P_LAG = 4'b1000
  } tms_phase_t;
endpackage : tms_pkg

/* File: tms_duty_if.sv */
`timescale 1ns/1ps
interface tms_duty_if;
  logic gate_req;
  logic gate_ok;
  logic trip;
  modport ctl (output gate_req, input gate_ok, input trip);
  modport lim (input gate_req, output gate_ok, output trip);
endinterface : tms_duty_if

/* File: tms_duty_limiter.sv */
`timescale 1ns/1ps
module tms_duty_limiter #(
  parameter int unsigned NUM = tms_pkg::DUTY_NUM,
  parameter int unsigned DEN = tms_pkg::DUTY_DEN,
  parameter int unsigned BURST = tms_pkg::DUTY_BURST_CYC
) (
  // clock and reset
  input wire logic clock,
  input wire logic resetn,
  // gate request and verdict
  tms_duty_if.lim dl
);
  localparam logic [31:0] UP_ACC = 32'(DEN - NUM);
  localparam logic [31:0] DN_ACC = 32'(NUM);
  localparam logic [31:0] LIMIT_ACC = 32'(BURST * (DEN - NUM));

  generate
    if (NUM == 0 || NUM >= DEN || BURST == 0)
    begin : g_bad
      $error("duty ratio or burst out of range");
    end
  endgenerate

  typedef struct packed {
    logic [31:0] acc;
    logic blk;
  } tms_lim_st_t;
  tms_lim_st_t s_r, s_nxt;

  //////////////////////////////////////////////////////////////////////
  // leaky bucket: on-cycles fill by den-num, off-cycles drain by num, so the
  // long-run duty stays under num/den while one full pulse still fits
  assign dl.gate_ok = (s_r.acc <= LIMIT_ACC);
  assign dl.trip = dl.gate_req & ~dl.gate_ok & ~s_r.blk; // onset of suppression only

  always_comb
  begin
    s_nxt = s_r;
    s_nxt.blk = dl.gate_req & ~dl.gate_ok;
    if (dl.gate_req && dl.gate_ok)
      s_nxt.acc = s_r.acc + UP_ACC;
    else if (s_r.acc >= DN_ACC)
      s_nxt.acc = s_r.acc - DN_ACC;
    else
      s_nxt.acc = 32'h0;
  end

  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
      s_r <= '0;
    else
      s_r <= s_nxt;
  end

  //////////////////////////////////////////////////////////////////////
  acc_bound_a: assert property (@(posedge clock) disable iff (!resetn)
    s_r.acc <= LIMIT_ACC + UP_ACC) else $error("duty bucket overflowed");
  acc_drain_a: assert property (@(posedge clock) disable iff (!resetn)
    (!dl.gate_req && s_r.acc >= DN_ACC) |=> s_r.acc == $past(s_r.acc) - DN_ACC)
    else $error("duty bucket did not drain");
endmodule : tms_duty_limiter

/* File: tms_sequencer.sv */
// How it works
// - off: no supplies; idle: heater and bias; armed: adds high voltage.
// - radiating keeps armed supplies and pulses once per trigger; never elsewhere.
// - climbing goes one step at a time: 10 s, 10 min, 10 s.
// - going down steps one mode per cycle with no wait.
// - a fault drops at once to its designated lower mode.
// - after a fault, climbing is refused until a reset command clears it.
// - body or cathode fault to idle, reflected to armed, bus to off.
// - trigger and pulse-width command produce the gate and internal timing.
// - blanking pulse starts before and ends after each gate pulse.
// - converter sync pulses come from the clock, realigned on each trigger.
// - the gate pulse drives the grid pulse coupler driver.
// - a duty limiter suppresses or truncates gates beyond the safe duty.
// - monitor samples analog channels and sends results to the bay electronics.
`timescale 1ns/1ps
module tms_sequencer #(
  parameter logic [33:0] STEP_CYC = 34'(tms_pkg::STEP_DLY_CYC),
  parameter logic [33:0] WARM_CYC = 34'(tms_pkg::WARM_DLY_CYC)
) (
  // clock and reset
  input wire logic clock,
  input wire logic resetn,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic irq,
  // processor timing pin and fault comparators
  input wire logic prf_trig,
  input wire logic flt_body_oc,
  input wire logic flt_refl_op,
  input wire logic flt_cath_ov,
  input wire logic flt_bus_oc,
  // supply enables
  output logic heater_en,
  output logic bias_en,
  output logic hv_en,
  // pulse outputs
  output logic grid_pulse_coupler_drive,
  output logic rx_blank,
  output logic conv_sync,
  // monitor converter and bay link
  input wire logic [11:0] adc_data,
  output logic [2:0] adc_chan,
  output logic adc_strobe,
  output logic [15:0] bay_data,
  output logic bay_valid
);
  generate
    if (STEP_CYC == 34'h0 || WARM_CYC == 34'h0)
    begin : g_bad
      $error("mode step delays must be at least one cycle");
    end
  endgenerate

  typedef struct packed {
    tms_pkg::tms_mode_t mode;
    logic [1:0] tgt;
    logic [33:0] tmr;
    logic [3:0] lat;
    logic [3:0] fs1;
    logic [3:0] fs2;
    logic [3:0] fs3;
    logic [3:0] fst;
    logic ts1;
    logic ts2;
    logic ts3;
    logic tst;
    logic tprev;
    tms_pkg::tms_phase_t ph;
    logic [15:0] cnt;
    logic gate;
    logic blank;
    logic [15:0] pw;
    logic [15:0] ccnt;
    logic csync;
    logic [15:0] mcnt;
    logic [2:0] mchan;
    logic mstb;
    logic [15:0] bay;
    logic bayv;
    logic [5:0] ist;
    logic [5:0] imsk;
    logic irq;
    logic ack;
    logic [31:0] dat;
  } tms_st_t;
  tms_st_t s_r, s_nxt;

  tms_duty_if dl ();

  //////////////////////////////////////////////////////////////////////
  // mode encoding and byte-mask helpers, used by the sequencer, the bus and the checks
  function automatic logic [1:0] tms_idx(input tms_pkg::tms_mode_t m);
    case (m)
      tms_pkg::M_IDLE: tms_idx = 2'h1;
      tms_pkg::M_ARM: tms_idx = 2'h2;
      tms_pkg::M_RAD: tms_idx = 2'h3;
      default: tms_idx = 2'h0;
    endcase
  endfunction : tms_idx

  function automatic tms_pkg::tms_mode_t tms_mode(input logic [1:0] i);
    case (i)
      2'h1: tms_mode = tms_pkg::M_IDLE;
      2'h2: tms_mode = tms_pkg::M_ARM;
      2'h3: tms_mode = tms_pkg::M_RAD;
      default: tms_mode = tms_pkg::M_OFF;
    endcase
  endfunction : tms_mode

  function automatic logic [31:0] tms_bmask(input logic [3:0] sel);
    tms_bmask = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
  endfunction : tms_bmask

  logic [1:0] midx;
  logic [1:0] flr;
  logic [3:0] fagree;
  logic tagree;
  logic trig_rise;
  logic locked;
  logic any_f;
  logic wr;
  logic clr_cmd;
  logic [31:0] bm;
  logic [31:0] pwm;
  logic [33:0] dly;
  logic [5:0] ev;
  logic [5:0] w1c;

  assign midx = tms_idx(s_r.mode);
  assign locked = |s_r.lat;

  //////////////////////////////////////////////////////////////////////
  // supplies decode straight from the mode register
  assign heater_en = (s_r.mode != tms_pkg::M_OFF);
  assign bias_en = (s_r.mode != tms_pkg::M_OFF);
  assign hv_en = (s_r.mode == tms_pkg::M_ARM) || (s_r.mode == tms_pkg::M_RAD);
  assign grid_pulse_coupler_drive = s_r.gate;
  assign rx_blank = s_r.blank;
  assign conv_sync = s_r.csync;
  assign adc_chan = s_r.mchan;
  assign adc_strobe = s_r.mstb;
  assign bay_data = s_r.bay;
  assign bay_valid = s_r.bayv;
  assign irq = s_r.irq;
  assign wb_ack_o = s_r.ack;
  assign wb_dat_o = s_r.dat;

  // gate request to the limiter only while radiating
  assign dl.gate_req = (s_r.ph == tms_pkg::P_GATE) && (s_r.mode == tms_pkg::M_RAD);

  tms_duty_limiter #(
    .NUM(tms_pkg::DUTY_NUM),
    .DEN(tms_pkg::DUTY_DEN),
    .BURST(tms_pkg::DUTY_BURST_CYC)
  ) u_lim (
    .clock(clock),
    .resetn(resetn),
    .dl(dl.lim)
  );

  //////////////////////////////////////////////////////////////////////
  // next-state logic
  always_comb
  begin
    s_nxt = s_r;
    // pin synchronisers: a change counts once stages two and three agree
    s_nxt.fs1 = {flt_bus_oc, flt_cath_ov, flt_refl_op, flt_body_oc};
    s_nxt.fs2 = s_r.fs1;
    s_nxt.fs3 = s_r.fs2;
    fagree = ~(s_r.fs2 ^ s_r.fs3);
    s_nxt.fst = (s_r.fst & ~fagree) | (s_r.fs2 & fagree);
    s_nxt.ts1 = prf_trig;
    s_nxt.ts2 = s_r.ts1;
    s_nxt.ts3 = s_r.ts2;
    tagree = (s_r.ts2 == s_r.ts3);
    s_nxt.tst = tagree ? s_r.ts2 : s_r.tst;
    s_nxt.tprev = s_r.tst;
    trig_rise = s_r.tst & ~s_r.tprev;

    // bus: ack one cycle after the strobe, dropped the cycle after
    s_nxt.ack = wb_cyc_i & wb_stb_i & ~s_r.ack;
    wr = s_r.ack & wb_cyc_i & wb_stb_i & wb_we_i; // lands at the edge the master samples ack
    bm = tms_bmask(wb_sel_i);
    clr_cmd = 1'b0;
    w1c = 6'h0;
    pwm = (32'(s_r.pw) & ~bm) | (wb_dat_i & bm);
    if (wr && {wb_adr_i[7:2], 2'h0} == tms_pkg::REG_CTRL && wb_sel_i[0])
    begin
      // upward requests are ignored while a fault is latched
      if (!locked || wb_dat_i[1:0] <= midx)
        s_nxt.tgt = wb_dat_i[1:0];
      clr_cmd = wb_dat_i[tms_pkg::CTRL_CLR_BIT];
    end
    if (wr && {wb_adr_i[7:2], 2'h0} == tms_pkg::REG_PW)
      s_nxt.pw = pwm[15:0];
    if (wr && {wb_adr_i[7:2], 2'h0} == tms_pkg::REG_IST)
      w1c = wb_dat_i[5:0] & bm[5:0];
    if (wr && {wb_adr_i[7:2], 2'h0} == tms_pkg::REG_IMSK)
      s_nxt.imsk = (s_r.imsk & ~bm[5:0]) | (wb_dat_i[5:0] & bm[5:0]);
    if (s_nxt.ack && !wb_we_i)
    begin
      case ({wb_adr_i[7:2], 2'h0})
        tms_pkg::REG_CTRL: s_nxt.dat = {30'h0, s_r.tgt};
        tms_pkg::REG_STAT: s_nxt.dat = {20'h0, s_r.fst, s_r.lat, s_r.tgt, midx};
        tms_pkg::REG_PW: s_nxt.dat = {16'h0, s_r.pw};
        tms_pkg::REG_IST: s_nxt.dat = {26'h0, s_r.ist};
        tms_pkg::REG_IMSK: s_nxt.dat = {26'h0, s_r.imsk};
        tms_pkg::REG_MON: s_nxt.dat = {16'h0, s_r.bay};
        default: s_nxt.dat = 32'h0; // unmapped reads zero, still acked
      endcase
    end

    // fault floor: deepest mode demanded by any live fault
    any_f = |s_r.fst;
    flr = 2'h3;
    if (s_r.fst[tms_pkg::F_REFL])
      flr = 2'h2;
    if (s_r.fst[tms_pkg::F_BODY] || s_r.fst[tms_pkg::F_CATH])
      flr = 2'h1;
    if (s_r.fst[tms_pkg::F_BUS])
      flr = 2'h0;
    // a fault still present keeps its latch even across a reset command
    if (clr_cmd)
      s_nxt.lat = s_r.fst;
    else
      s_nxt.lat = s_r.lat | s_r.fst;
    if (any_f && s_nxt.tgt > flr)
      s_nxt.tgt = flr; // a new request is needed to climb again

    // mode sequencing
    dly = (midx == 2'h1) ? WARM_CYC : STEP_CYC;
    if (any_f && flr < midx)
    begin
      s_nxt.mode = tms_mode(flr);
      s_nxt.tmr = 34'h0;
    end
    else if (s_r.tgt < midx)
    begin
      s_nxt.mode = tms_mode(midx - 2'h1);
      s_nxt.tmr = 34'h0;
    end
    else if (s_r.tgt > midx && !locked && !any_f)
    begin
      if (s_r.tmr >= dly - 34'h1)
      begin
        s_nxt.mode = tms_mode(midx + 2'h1);
        s_nxt.tmr = 34'h0;
      end
      else
        s_nxt.tmr = s_r.tmr + 34'h1;
    end
    else
      s_nxt.tmr = 34'h0;

    // pulse timing: blank leads, gate for pw cycles, blank lags
    case (s_r.ph)
      tms_pkg::P_IDLE:
        if (trig_rise && s_r.mode == tms_pkg::M_RAD)
        begin
          s_nxt.ph = tms_pkg::P_LEAD;
          s_nxt.cnt = tms_pkg::BLANK_LEAD_CYC;
        end
      tms_pkg::P_LEAD:
        if (s_r.mode != tms_pkg::M_RAD)
        begin
          s_nxt.ph = tms_pkg::P_LAG;
          s_nxt.cnt = tms_pkg::BLANK_LAG_CYC;
        end
        else if (s_r.cnt <= 16'h1)
        begin
          s_nxt.ph = tms_pkg::P_GATE;
          s_nxt.cnt = s_r.pw;
        end
        else
          s_nxt.cnt = s_r.cnt - 16'h1;
      tms_pkg::P_GATE:
        if (!dl.gate_ok || s_r.mode != tms_pkg::M_RAD || s_r.cnt <= 16'h1)
        begin
          s_nxt.ph = tms_pkg::P_LAG;
          // a gate cut short already fell at this edge, so its lag is one cycle shorter
          s_nxt.cnt = (dl.gate_req && dl.gate_ok) ? tms_pkg::BLANK_LAG_CYC : tms_pkg::BLANK_LAG_CYC - 16'h1;
        end
        else
          s_nxt.cnt = s_r.cnt - 16'h1;
      tms_pkg::P_LAG:
        if (s_r.cnt <= 16'h1)
          s_nxt.ph = tms_pkg::P_IDLE;
        else
          s_nxt.cnt = s_r.cnt - 16'h1;
      default:
      begin
        s_nxt.ph = tms_pkg::P_IDLE;
        s_nxt.cnt = 16'h0;
      end
    endcase
    // outputs lag the phase by one cycle together, so the overlap holds
    s_nxt.gate = dl.gate_req & dl.gate_ok;
    s_nxt.blank = (s_r.ph != tms_pkg::P_IDLE);

    // converter sync: free running, restarted on each trigger
    if (trig_rise || s_r.ccnt >= tms_pkg::CONV_PERIOD_CYC - 16'h1)
    begin
      s_nxt.ccnt = 16'h0;
      s_nxt.csync = 1'b1;
    end
    else
    begin
      s_nxt.ccnt = s_r.ccnt + 16'h1;
      s_nxt.csync = 1'b0;
    end

    // monitor: strobe the converter, take its word a cycle later
    s_nxt.mstb = 1'b0;
    s_nxt.bayv = 1'b0;
    if (s_r.mcnt >= tms_pkg::MON_PERIOD_CYC - 16'h1)
    begin
      s_nxt.mcnt = 16'h0;
      s_nxt.mstb = 1'b1;
    end
    else
      s_nxt.mcnt = s_r.mcnt + 16'h1;
    if (s_r.mstb)
    begin
      s_nxt.bay = {1'b0, s_r.mchan, adc_data};
      s_nxt.bayv = 1'b1;
      s_nxt.mchan = s_r.mchan + 3'h1;
    end

    // interrupts: set wins over a write-one clear in the same cycle
    ev = {dl.trip, s_nxt.mode != s_r.mode, s_nxt.fst & ~s_r.fst};
    s_nxt.ist = (s_r.ist & ~w1c) | ev;
    s_nxt.irq = |(s_nxt.ist & s_nxt.imsk);
  end

  //////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      s_r <= '0;
      s_r.mode <= tms_pkg::M_OFF;
      s_r.ph <= tms_pkg::P_IDLE;
      s_r.pw <= tms_pkg::PW_RST;
    end
    else
      s_r <= s_nxt;
  end

  //////////////////////////////////////////////////////////////////////
  // checks
  logic [1:0] tidx;
  assign tidx = s_r.tgt;

  no_pulse_a: assert property (@(posedge clock) disable iff (!resetn)
    s_r.gate |-> $past(s_r.mode) == tms_pkg::M_RAD) else $error("gate outside radiating");
  blank_cover_a: assert property (@(posedge clock) disable iff (!resetn)
    (s_r.gate || $fell(s_r.gate)) |-> s_r.blank) else $error("gate not covered by blank");
  blank_lead_a: assert property (@(posedge clock) disable iff (!resetn)
    $rose(s_r.gate) |-> $past(s_r.blank)) else $error("blank did not lead gate");
  bus_drop_a: assert property (@(posedge clock) disable iff (!resetn)
    s_r.fst[tms_pkg::F_BUS] |=> s_r.mode == tms_pkg::M_OFF) else $error("bus fault not off");
  body_drop_a: assert property (@(posedge clock) disable iff (!resetn)
    (s_r.fst[tms_pkg::F_BODY] || s_r.fst[tms_pkg::F_CATH]) |=> midx <= 2'h1)
    else $error("tube fault not idle");
  refl_drop_a: assert property (@(posedge clock) disable iff (!resetn)
    s_r.fst[tms_pkg::F_REFL] |=> midx <= 2'h2) else $error("reflected fault not armed");
  lock_hold_a: assert property (@(posedge clock) disable iff (!resetn)
    locked |=> midx <= $past(midx)) else $error("climbed while locked");
  step_one_a: assert property (@(posedge clock) disable iff (!resetn)
    (midx > $past(midx)) |-> (midx == $past(midx) + 2'h1) && ($past(s_r.tmr) != 34'h0 || STEP_CYC == 34'h1))
    else $error("climb skipped a mode or a delay");
  step_down_a: assert property (@(posedge clock) disable iff (!resetn)
    (tidx < midx) |=> midx < $past(midx)) else $error("turn-off step delayed");
  wb_ack_a: assert property (@(posedge clock) disable iff (!resetn)
    (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o ##1 !wb_ack_o) else $error("bus ack timing");
  irq_set_a: assert property (@(posedge clock) disable iff (!resetn)
    $rose(s_r.fst[tms_pkg::F_BUS]) |=> s_r.ist[tms_pkg::F_BUS]) else $error("fault event lost");
endmodule : tms_sequencer

/* File: tms_proc_model.sv */
`timescale 1ns/1ps
module tms_proc_model #(
  parameter int HI_CYC = 3
) (
  // clock and reset
  input wire logic clock,
  input wire logic resetn,
  // trigger request from the bench, trigger pin to the block
  input wire logic fire,
  output logic prf_trig
);
  int cnt;
  ////////////////////////////////////////////////////////////////////////////////
  // trigger is stretched over several clocks so the three-flop sync never misses it
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      cnt <= 0;
      prf_trig <= 1'b0;
    end
    else if (fire)
    begin
      cnt <= HI_CYC;
      prf_trig <= 1'b1;
    end
    else if (cnt > 0)
    begin
      cnt <= cnt - 1;
      prf_trig <= (cnt > 1);
    end
  end
endmodule : tms_proc_model

/* File: testbench.sv */
`timescale 1ns/1ps
module testbench;
  localparam int STEP = 20;
  localparam int WARM = 50;
  logic clock, resetn, wb_cyc_i, wb_stb_i, wb_we_i, fire, prf_trig;
  logic [7:0] wb_adr_i;
  logic [3:0] wb_sel_i, flt;
  logic [31:0] wb_dat_i, wb_dat_o, rd;
  logic [11:0] adc_data;
  logic wb_ack_o, irq, heater_en, bias_en, hv_en, gate, rx_blank, conv_sync, adc_strobe, bay_valid;
  logic [2:0] adc_chan;
  logic [15:0] bay_data;
  int n_fail, n_compared;
  ////////////////////////////////////////////////////////////////////////////////
  // short delays keep the run to ten to fifteen thousand cycles
  tms_sequencer #(.STEP_CYC(34'd20), .WARM_CYC(34'd50)) uut (.clock(clock), .resetn(resetn),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .irq(irq), .prf_trig(prf_trig),
    .flt_body_oc(flt[0]), .flt_refl_op(flt[1]), .flt_cath_ov(flt[2]), .flt_bus_oc(flt[3]),
    .heater_en(heater_en), .bias_en(bias_en), .hv_en(hv_en), .grid_pulse_coupler_drive(gate),
    .rx_blank(rx_blank), .conv_sync(conv_sync), .adc_data(adc_data), .adc_chan(adc_chan),
    .adc_strobe(adc_strobe), .bay_data(bay_data), .bay_valid(bay_valid));
  // slow trigger variant of the processor
  tms_proc_model #(.HI_CYC(5)) proc (.clock(clock), .resetn(resetn), .fire(fire), .prf_trig(prf_trig));
  ////////////////////////////////////////////////////////////////////////////////
  // clock and watchdog
  initial
  begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  initial
  begin
    #(50 * 40000);
    n_fail++;
    report_and_stop();
  end
  ////////////////////////////////////////////////////////////////////////////////
  // shared helpers
  task automatic report_and_stop();
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : report_and_stop
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  // classic single cycle; ack is sampled at the edge, request dropped there
  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
    int t;
    @(posedge clock);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_sel_i <= 4'hf;
    wb_adr_i <= adr;
    wb_dat_i <= dat;
    t = 0;
    do
    begin
      @(posedge clock);
      t++;
    end
    while (wb_ack_o !== 1'b1 && t < 20);
    rd = wb_dat_o;
    if (t >= 20)
      check("bus ack", 32'h0, 32'h1);
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask : wb
  function automatic logic sig(input int w);
    case (w)
      0: return heater_en;
      1: return hv_en;
      2: return rx_blank;
      3: return gate;
      4: return conv_sync;
      5: return adc_strobe;
      default: return bay_valid;
    endcase
  endfunction : sig
  // counts edges until the chosen output shows the level, bounded by lim
  task automatic wait_sig(input int w, input logic lvl, input int lim, output int n);
    n = 0;
    do
    begin
      @(posedge clock);
      n++;
    end
    while (sig(w) !== lvl && n < lim);
  endtask : wait_sig
  task automatic fire_trig();
    @(posedge clock);
    fire <= 1'b1;
    @(posedge clock);
    fire <= 1'b0;
  endtask : fire_trig
  ////////////////////////////////////////////////////////////////////////////////
  // scenarios
  task automatic t_climb();
    int n;
    repeat (40) @(posedge clock);
    check("no request stays off", {heater_en, bias_en, hv_en}, 0);
    wb(0, tms_pkg::REG_PW, 0); check("pw reset", rd, 32'(tms_pkg::PW_RST));
    wb(1, tms_pkg::REG_PW, 32'hffff_0123);
    wb(0, tms_pkg::REG_PW, 0); check("pw upper bits", rd, 32'h0123);
    wb(0, 8'h40, 0); check("unmapped read", rd, 0);
    wb(1, tms_pkg::REG_IMSK, 32'h3f);
    wb(1, tms_pkg::REG_CTRL, 32'h3);
    wait_sig(0, 1, 100, n);
    check("idle step delay", n >= STEP && n <= STEP + 4, 1);
    check("idle supplies", {bias_en, hv_en}, 2'b10);
    wait_sig(1, 1, 200, n);
    check("armed step delay", n >= WARM && n <= WARM + 4, 1);
    wb(0, tms_pkg::REG_STAT, 0); check("one step at a time", rd[1:0], 2);
    repeat (STEP + 4) @(posedge clock);
    wb(0, tms_pkg::REG_STAT, 0); check("radiating", rd[1:0], 3);
  endtask : t_climb
  task automatic t_pulse(input int pw);
    int n, lead, w, lag;
    wb(1, tms_pkg::REG_PW, pw);
    fire_trig();
    wait_sig(2, 1, 50, n);
    wait_sig(3, 1, 20, lead);
    wait_sig(3, 0, 1000, w);
    wait_sig(2, 0, 20, lag);
    check("blank before gate", lead, 4);
    check("blank after gate", lag, 4);
    if (pw < 500)
      check("gate width", w, pw);
    else
    begin
      check("gate truncated", w >= 490 && w <= 501, 1);
      wb(0, tms_pkg::REG_IST, 0); check("duty trip flag", rd[5], 1);
    end
  endtask : t_pulse
  task automatic t_sync_mon();
    int n;
    logic [2:0] c;
    wait_sig(4, 1, 5000, n);
    wait_sig(4, 1, 5000, n); check("sync period", n, 4000);
    wait_sig(5, 1, 2100, n);
    wait_sig(6, 1, 4, n); check("sample after strobe", n, 1);
    c = bay_data[14:12];
    check("bay word", {bay_data[15], bay_data[11:0]}, {1'b0, adc_data});
    check("channel out", adc_chan, 3'(c + 3'h1));
    wait_sig(6, 1, 2100, n); check("monitor period", n, 2000);
    check("channel steps", bay_data[14:12], 3'(c + 3'h1));
    wb(0, tms_pkg::REG_MON, 0); check("monitor register", rd[15:0], bay_data);
  endtask : t_sync_mon
  task automatic t_fault(input int f, input logic [1:0] floor);
    int n;
    wb(1, tms_pkg::REG_CTRL, 32'h3);
    repeat (STEP * 2 + WARM + 10) @(posedge clock);
    wb(1, tms_pkg::REG_IST, 32'h3f);
    flt[f] <= 1'b1;
    repeat (8) @(posedge clock);
    wb(0, tms_pkg::REG_STAT, 0); check("fault floor", rd[1:0], floor);
    check("fault latched", rd[4 + f], 1);
    check("floor supplies", {heater_en, hv_en}, {floor != 0, floor >= 2});
    wb(0, tms_pkg::REG_IST, 0); check("fault event", rd[f], 1);
    fire_trig();
    wait_sig(3, 1, 40, n); check("no gate below radiating", n, 40);
    check("irq raised", irq, 1);
    wb(1, tms_pkg::REG_IMSK, 0);
    repeat (2) @(posedge clock);
    check("irq masked", irq, 0);
    wb(1, tms_pkg::REG_IMSK, 32'h3f);
    flt[f] <= 1'b0;
    wb(1, tms_pkg::REG_CTRL, 32'h3);
    repeat (STEP * 2 + WARM + 10) @(posedge clock);
    wb(0, tms_pkg::REG_STAT, 0); check("locked out", rd[1:0], floor);
    wb(1, tms_pkg::REG_CTRL, 32'h4 | 32'(floor));
    wb(0, tms_pkg::REG_STAT, 0); check("latch cleared", rd[7:4], 0);
    wb(1, tms_pkg::REG_IST, 32'h3f);
    wb(0, tms_pkg::REG_IST, 0); check("status cleared", rd[5:0], 0);
    repeat (2) @(posedge clock);
    check("irq cleared", irq, 0);
  endtask : t_fault
  task automatic t_down();
    int a, b;
    wb(1, tms_pkg::REG_CTRL, 32'h3);
    repeat (STEP * 2 + WARM + 10) @(posedge clock);
    wb(1, tms_pkg::REG_CTRL, 32'h0);
    wait_sig(1, 0, 20, a);
    wait_sig(0, 0, 20, b);
    check("fast turnoff", a <= 4, 1);
    check("no wait between steps", b, 1);
  endtask : t_down
  ////////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial
  begin
    resetn = 1'b0;
    {wb_cyc_i, wb_stb_i, wb_we_i, fire} = 4'h0;
    wb_adr_i = 8'h00;
    wb_sel_i = 4'hf;
    wb_dat_i = 32'h0;
    flt = 4'h0;
    adc_data = 12'h5a3;
    repeat (3) @(posedge clock);
    resetn <= 1'b1;
    t_climb();
    t_pulse(10);
    t_pulse(7);
    t_sync_mon();
    t_pulse(600);
    t_fault(tms_pkg::F_BODY, 2'd1);
    t_fault(tms_pkg::F_REFL, 2'd2);
    t_fault(tms_pkg::F_CATH, 2'd1);
    t_fault(tms_pkg::F_BUS, 2'd0);
    t_down();
    report_and_stop();
  end
endmodule : testbench
